// >>> emcc_pkg.sv
package emcc_pkg;

    // Command block layout
    localparam logic [7:0] OPC_EXCHANGE = 8'hA6;
    localparam int FLIP_ONE_BIT = 8;
    localparam int FLIP_TWO_BIT = 9;

    // Register byte addresses
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_CDB0 = 8'h04;
    localparam logic [7:0] A_CDB1 = 8'h08;
    localparam logic [7:0] A_CDB2 = 8'h0C;
    localparam logic [7:0] A_HANDLER = 8'h10;
    localparam logic [7:0] A_ENV = 8'h14;
    localparam logic [7:0] A_RESULT = 8'h18;
    localparam logic [7:0] A_SENSE = 8'h1C;
    localparam logic [7:0] A_FIELD = 8'h20;
    localparam logic [7:0] A_IRQ_STS = 8'h24;
    localparam logic [7:0] A_IRQ_MASK = 8'h28;

    // Control bits
    localparam int CTRL_START = 0;
    localparam int CTRL_TEMP = 1;
    localparam int CTRL_ALT = 2;

    // Element environment bits
    localparam int ENV_W = 18;
    localparam int E_SRC_OK = 0;
    localparam int E_D1_OK = 1;
    localparam int E_D2_OK = 2;
    localparam int E_SRC_FULL = 3;
    localparam int E_D1_FULL = 4;
    localparam int E_D2_FULL = 5;
    localparam int E_SRC_IO = 6;
    localparam int E_D1_IO = 7;
    localparam int E_D2_IO = 8;
    localparam int E_IO_BAN = 9;
    localparam int E_NOT_EJECT = 10;
    localparam int E_HFULL = 11;
    localparam int E_SMAG = 12;
    localparam int E_DMAG = 13;
    localparam int E_SDRV = 14;
    localparam int E_DDRV = 15;
    localparam int E_FREE = 16;
    localparam int E_ABORT = 17;

    // Handler reset value and the transport address that means handler
    localparam logic [15:0] HANDLER_RST = 16'h0001;
    localparam logic [15:0] XPORT_SELF = 16'h0000;

    // Move plans
    localparam logic [1:0] PLAN_NONE = 2'h0;
    localparam logic [1:0] PLAN_SWAP_FREE = 2'h1;
    localparam logic [1:0] PLAN_SWAP_PRIV = 2'h2;
    localparam logic [1:0] PLAN_THREE = 2'h3;

    // Sense values
    localparam logic [3:0] SK_NOT_READY = 4'h2;
    localparam logic [3:0] SK_ILLEGAL = 4'h5;
    localparam logic [7:0] ASC_NOT_READY = 8'h04;
    localparam logic [7:0] ASC_ELEM = 8'h3B;
    localparam logic [7:0] ASC_VND = 8'h80;
    localparam logic [7:0] ASC_ADDR_NAT = 8'h21;
    localparam logic [7:0] ASC_ADDR_ALT = 8'h24;
    localparam logic [7:0] ASC_BAD_OPC = 8'h20;
    localparam logic [7:0] ASC_BAD_FIELD = 8'h24;
    localparam logic [7:0] Q_ZERO = 8'h00;
    localparam logic [7:0] Q_D2_FULL = 8'h0D;
    localparam logic [7:0] Q_SRC_EMPTY = 8'h0E;
    localparam logic [7:0] Q_IO_BAN = 8'h07;
    localparam logic [7:0] Q_ADDR_NAT = 8'h01;
    localparam logic [7:0] Q_ADDR_ALT = 8'h80;
    localparam logic [7:0] Q_EJECT_NAT = 8'h90;
    localparam logic [7:0] Q_EJECT_ALT = 8'h83;
    localparam logic [7:0] Q_HFULL = 8'h01;
    localparam logic [7:0] Q_SMAG = 8'h03;
    localparam logic [7:0] Q_DMAG = 8'h04;
    localparam logic [7:0] Q_SDRV = 8'h05;
    localparam logic [7:0] Q_DDRV = 8'h06;
    localparam logic [7:0] Q_MAG_ALT = 8'h86;
    localparam logic [7:0] Q_DDRV_ALT = 8'h84;
    localparam logic [15:0] FP_OPC = 16'h0000;
    localparam logic [15:0] FP_XPORT = 16'h0002;
    localparam logic [15:0] FP_SRC = 16'h0004;
    localparam logic [15:0] FP_D1 = 16'h0006;
    localparam logic [15:0] FP_D2 = 16'h0008;
    localparam logic [15:0] FP_FLIP = 16'h000A;

    typedef enum logic [4:0] {
        ERR_NONE, ERR_OPC, ERR_FLIP, ERR_XPORT, ERR_SRC, ERR_D1, ERR_D2,
        ERR_SMAG, ERR_DMAG, ERR_SDRV, ERR_DDRV, ERR_IO_SRC, ERR_IO_D1,
        ERR_IO_D2, ERR_EJECT, ERR_HFULL, ERR_SRC_EMPTY, ERR_D1_EMPTY,
        ERR_D2_FULL, ERR_NO_TEMP
    } emcc_err_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_CHECK = 2'b01,
        ST_REPORT = 2'b11
    } emcc_fsm_t;

endpackage

// >>> emcc_sense_map.sv
`timescale 1ns/10ps
`default_nettype none
module emcc_sense_map
(
    // Error and mode
    input wire emcc_pkg::emcc_err_t err,
    input wire logic alt_mode,
    // Sense fields
    output logic [3:0] key,
    output logic [7:0] asc,
    output logic [7:0] ascq,
    output logic cd,
    output logic fpv,
    output logic [15:0] fp
);
    import emcc_pkg::*;

    always_comb
    begin
        key = SK_ILLEGAL;
        asc = ASC_VND;
        ascq = Q_ZERO;
        cd = 1'b1;
        fpv = 1'b1;
        fp = FP_OPC;
        case (err)
            ERR_OPC:
            begin
                asc = ASC_BAD_OPC;
            end
            ERR_FLIP:
            begin
                asc = ASC_BAD_FIELD;
                fp = FP_FLIP;
            end
            ERR_XPORT, ERR_SRC, ERR_D1, ERR_D2:
            begin
                asc = alt_mode ? ASC_ADDR_ALT : ASC_ADDR_NAT; // R14 R17
                ascq = alt_mode ? Q_ADDR_ALT : Q_ADDR_NAT; // R14 R17
                fp = (err == ERR_XPORT) ? FP_XPORT : (err == ERR_SRC) ? FP_SRC :
                    (err == ERR_D1) ? FP_D1 : FP_D2;
            end
            ERR_EJECT:
            begin
                asc = ASC_ELEM;
                ascq = alt_mode ? Q_EJECT_ALT : Q_EJECT_NAT; // R15 R17
                fp = FP_SRC;
            end
            ERR_HFULL:
            begin
                ascq = Q_HFULL; // R15 R17
                fp = FP_XPORT;
            end
            ERR_SMAG, ERR_DMAG:
            begin
                cd = 1'b0;
                fpv = 1'b0;
                if (alt_mode)
                begin
                    key = SK_NOT_READY; // R18
                    asc = ASC_NOT_READY;
                    ascq = Q_MAG_ALT;
                end
                else
                begin
                    ascq = (err == ERR_SMAG) ? Q_SMAG : Q_DMAG; // R16
                end
            end
            ERR_SDRV, ERR_DDRV:
            begin
                cd = 1'b0;
                fpv = 1'b0;
                if (alt_mode)
                begin
                    asc = ASC_ELEM; // R18
                    ascq = (err == ERR_SDRV) ? Q_EJECT_ALT : Q_DDRV_ALT;
                end
                else
                begin
                    ascq = (err == ERR_SDRV) ? Q_SDRV : Q_DDRV; // R16
                end
            end
            ERR_IO_SRC, ERR_IO_D1, ERR_IO_D2:
            begin
                ascq = Q_IO_BAN; // R13
                fp = (err == ERR_IO_SRC) ? FP_SRC : (err == ERR_IO_D1) ? FP_D1 : FP_D2;
            end
            ERR_SRC_EMPTY:
            begin
                asc = ASC_ELEM; // R12
                ascq = Q_SRC_EMPTY;
                fp = FP_SRC;
            end
            ERR_D1_EMPTY:
            begin
                fp = FP_D1; // R12
            end
            ERR_D2_FULL:
            begin
                asc = ASC_ELEM; // R11
                ascq = Q_D2_FULL;
                fp = FP_D2;
            end
            ERR_NO_TEMP:
            begin
                key = SK_NOT_READY; // R10
                asc = ASC_NOT_READY;
                cd = 1'b0;
                fpv = 1'b0;
            end
            default:
            begin
                key = 4'h0;
                asc = Q_ZERO;
                cd = 1'b0;
                fpv = 1'b0;
            end
        endcase
    end
endmodule
`default_nettype wire

// >>> emcc_exchange_checker.sv
// Functional notes
// R01 - Decode A6 opcode, four addresses, flip flags
// R02 - Swap borrows free slot, private slot last
// R03 - No temp location and private disabled fails
// R04 - Three-location: first to second, source to first
// R05 - Any element type accepted everywhere
// R06 - Empty source/first or occupied second rejected
// R07 - Transport zero means handler; else compare
// R08 - Second equal to source means swap
// R09 - Both flip flags must be zero
// R10 - No temp or abort: not ready 04/00
// R11 - Occupied second destination: 3B/0D, pointer 8
// R12 - Empty source 3B/0E; empty first 80/00
// R13 - Prohibited I/O port: 80/07 per field
// R14 - Native bad address: 21/01 per field
// R15 - Native not ejected 3B/90; full 80/01
// R16 - Native missing magazine/drive: 80/03..06
// R17 - Alternate bad address 24/80, eject 3B/83
// R18 - Alternate magazine 04/86, drives 3B/83, 3B/84
// R19 - Mode input selects sense table
`timescale 1ns/10ps
`default_nettype none
module emcc_exchange_checker
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Interrupt
    output logic irq
);
    import emcc_pkg::*;

    typedef struct packed {
        emcc_fsm_t fsm;
        logic pend;
        logic wr;
        logic [7:0] addr;
        logic hready;
        logic [31:0] hrdata;
        logic allow_tmp;
        logic alt_mode;
        logic [31:0] cdb0;
        logic [31:0] cdb1;
        logic [31:0] cdb2;
        logic [15:0] handler;
        logic [ENV_W-1:0] env;
        emcc_err_t err;
        logic [1:0] plan;
        logic [15:0] xport_eff;
        logic done;
        logic pass;
        logic [3:0] key;
        logic [7:0] asc;
        logic [7:0] ascq;
        logic cd;
        logic fpv;
        logic [15:0] fp;
        logic [1:0] sts;
        logic [1:0] mask;
        logic irq;
    } emcc_state_t;

    localparam emcc_state_t ST_RST = '{
        fsm: ST_IDLE,
        err: ERR_NONE,
        hready: 1'b1,
        handler: HANDLER_RST,
        default: '0
    };

    emcc_state_t s;
    emcc_state_t n;

    logic [7:0] opcode;
    logic [15:0] xport;
    logic [15:0] src;
    logic [15:0] dst1;
    logic [15:0] dst2;
    logic flip_flag_one;
    logic flip_flag_two;
    logic swap_req;
    emcc_err_t chk_err;
    logic [1:0] chk_plan;
    logic [3:0] m_key;
    logic [7:0] m_asc;
    logic [7:0] m_ascq;
    logic m_cd;
    logic m_fpv;
    logic [15:0] m_fp;
    logic accept;
    logic wr_hit;
    logic [1:0] set_sts;

    // Byte 0 sits in the top lane of the first word
    assign opcode = s.cdb0[31:24]; // R01
    assign xport = s.cdb0[15:0];
    assign src = s.cdb1[31:16];
    assign dst1 = s.cdb1[15:0];
    assign dst2 = s.cdb2[31:16];
    assign flip_flag_one = s.cdb2[FLIP_ONE_BIT];
    assign flip_flag_two = s.cdb2[FLIP_TWO_BIT];
    assign swap_req = (dst2 == src); // R08

    // Only word transfers are expected; hsize is not checked
    assign accept = hsel && htrans[1] && hready;

    // Checks run in a fixed priority; element type is never examined
    always_comb
    begin
        chk_err = ERR_NONE; // R05
        chk_plan = PLAN_NONE;
        if (opcode != OPC_EXCHANGE)
            chk_err = ERR_OPC; // R01
        else if (flip_flag_one || flip_flag_two)
            chk_err = ERR_FLIP; // R09
        else if (xport != XPORT_SELF && xport != s.handler)
            chk_err = ERR_XPORT; // R07
        else if (!s.env[E_SRC_OK])
            chk_err = ERR_SRC;
        else if (!s.env[E_D1_OK])
            chk_err = ERR_D1;
        else if (!s.env[E_D2_OK])
            chk_err = ERR_D2;
        else if (s.env[E_SMAG])
            chk_err = ERR_SMAG; // R16
        else if (s.env[E_DMAG])
            chk_err = ERR_DMAG;
        else if (s.env[E_SDRV])
            chk_err = ERR_SDRV;
        else if (s.env[E_DDRV])
            chk_err = ERR_DDRV;
        else if (s.env[E_IO_BAN] && s.env[E_SRC_IO])
            chk_err = ERR_IO_SRC; // R13
        else if (s.env[E_IO_BAN] && s.env[E_D1_IO])
            chk_err = ERR_IO_D1;
        else if (s.env[E_IO_BAN] && s.env[E_D2_IO])
            chk_err = ERR_IO_D2;
        else if (s.env[E_NOT_EJECT])
            chk_err = ERR_EJECT; // R15
        else if (s.env[E_HFULL])
            chk_err = ERR_HFULL;
        else if (!s.env[E_SRC_FULL])
            chk_err = ERR_SRC_EMPTY; // R06
        else if (!s.env[E_D1_FULL])
            chk_err = ERR_D1_EMPTY; // R06
        else if (!swap_req && s.env[E_D2_FULL])
            chk_err = ERR_D2_FULL; // R06
        else if (s.env[E_ABORT])
            chk_err = ERR_NO_TEMP; // R10
        else if (!swap_req)
            chk_plan = PLAN_THREE; // R04
        else if (s.env[E_FREE])
            chk_plan = PLAN_SWAP_FREE; // R02
        else if (s.allow_tmp)
            chk_plan = PLAN_SWAP_PRIV; // R02
        else
            chk_err = ERR_NO_TEMP; // R03
    end

    emcc_sense_map u_map
    (
        .err(s.err),
        .alt_mode(s.alt_mode), // R19
        .key(m_key),
        .asc(m_asc),
        .ascq(m_ascq),
        .cd(m_cd),
        .fpv(m_fpv),
        .fp(m_fp)
    );

    always_comb
    begin
        n = s;
        set_sts = 2'b00;
        wr_hit = s.pend && s.wr;
        n.hready = 1'b1;
        n.pend = 1'b0;
        // One wait state lets read data come from a flop
        if (accept)
        begin
            n.pend = 1'b1;
            n.wr = hwrite;
            n.addr = {haddr[7:2], 2'b00};
            n.hready = 1'b0;
        end
        if (s.pend && !s.wr)
        begin
            case (s.addr)
                A_CTRL: n.hrdata = {29'h0, s.alt_mode, s.allow_tmp, 1'b0};
                A_CDB0: n.hrdata = s.cdb0;
                A_CDB1: n.hrdata = s.cdb1;
                A_CDB2: n.hrdata = s.cdb2;
                A_HANDLER: n.hrdata = {16'h0, s.handler};
                A_ENV: n.hrdata = {{(32-ENV_W){1'b0}}, s.env};
                A_RESULT: n.hrdata = {s.xport_eff, 10'h0, s.plan,
                    1'b0, s.pass, s.done, s.fsm != ST_IDLE};
                A_SENSE: n.hrdata = {10'h0, s.fpv, s.cd, s.key, s.asc, s.ascq};
                A_FIELD: n.hrdata = {16'h0, s.fp};
                A_IRQ_STS: n.hrdata = {30'h0, s.sts};
                A_IRQ_MASK: n.hrdata = {30'h0, s.mask};
                default: n.hrdata = 32'h0;
            endcase
        end
        if (wr_hit)
        begin
            case (s.addr)
                A_CTRL:
                begin
                    n.allow_tmp = hwdata[CTRL_TEMP];
                    n.alt_mode = hwdata[CTRL_ALT]; // R19
                    // Start while busy is ignored
                    if (hwdata[CTRL_START] && s.fsm == ST_IDLE)
                    begin
                        n.fsm = ST_CHECK;
                        n.done = 1'b0;
                        n.pass = 1'b0;
                    end
                end
                A_CDB0: n.cdb0 = hwdata;
                A_CDB1: n.cdb1 = hwdata;
                A_CDB2: n.cdb2 = hwdata;
                A_HANDLER: n.handler = hwdata[15:0]; // R07
                A_ENV: n.env = hwdata[ENV_W-1:0];
                A_IRQ_MASK: n.mask = hwdata[1:0];
                default:
                begin
                end
            endcase
        end
        case (s.fsm)
            ST_IDLE:
            begin
            end
            ST_CHECK:
            begin
                n.err = chk_err;
                n.plan = chk_plan;
                n.xport_eff = (xport == XPORT_SELF) ? s.handler : xport; // R07
                n.fsm = ST_REPORT;
            end
            ST_REPORT:
            begin
                n.key = m_key;
                n.asc = m_asc;
                n.ascq = m_ascq;
                n.cd = m_cd;
                n.fpv = m_fpv;
                n.fp = m_fp;
                n.done = 1'b1;
                n.pass = (s.err == ERR_NONE);
                set_sts = (s.err == ERR_NONE) ? 2'b01 : 2'b10;
                n.fsm = ST_IDLE;
            end
            default: n.fsm = ST_IDLE;
        endcase
        // A new event wins over a same-cycle clear
        if (wr_hit && s.addr == A_IRQ_STS)
            n.sts = s.sts & ~hwdata[1:0];
        n.sts = n.sts | set_sts;
        n.irq = |(n.sts & n.mask);
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            s <= ST_RST;
        else
            s <= n;
    end

    assign hrdata = s.hrdata;
    assign hreadyout = s.hready;
    assign hresp = 1'b0;
    assign irq = s.irq;

endmodule
`default_nettype wire

// >>> emcc_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module emcc_sva
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Bus request
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    // Bus answer and interrupt
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic irq
);
    logic acc;
    logic rd_ph;
    logic wr_ph;
    logic [3:0] since_wr;
    assign acc = hsel && htrans[1] && hready;
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            rd_ph <= 1'b0;
            wr_ph <= 1'b0;
            since_wr <= 4'hF;
        end
        else
        begin
            rd_ph <= acc ? !hwrite : (hready ? 1'b0 : rd_ph);
            wr_ph <= acc ? hwrite : (hready ? 1'b0 : wr_ph);
            // Zeroed at the wait-state edge, where the slave stores the write
            // Saturates so a long quiet spell never wraps
            since_wr <= (wr_ph && !hready) ? 4'h0 :
                (since_wr == 4'hF ? since_wr : since_wr + 4'h1);
        end
    end
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    sequence s_take;
        acc;
    endsequence
    sequence s_one_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    property p_xfer;
        s_take |=> s_one_wait;
    endproperty
    a_xfer: assert property (p_xfer) else $error("transfer wait state wrong");
    property p_one_wait;
        !hreadyout |=> hreadyout;
    endproperty
    a_one_wait: assert property (p_one_wait) else $error("ready low too long");
    property p_idle;
        hreadyout && !acc |=> hreadyout;
    endproperty
    a_idle: assert property (p_idle) else $error("ready dropped without transfer");
    property p_okay;
        hresp == 1'b0;
    endproperty
    a_okay: assert property (p_okay) else $error("response not okay");
    property p_rdata;
        $changed(hrdata) |-> $past(rd_ph && !hreadyout);
    endproperty
    a_rdata: assert property (p_rdata) else $error("read data moved outside a read");
    property p_irq_rise;
        $rose(irq) |-> since_wr <= 4'h5;
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("interrupt rose late");
    property p_irq_fall;
        $fell(irq) |-> since_wr <= 4'h3;
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("interrupt fell without write");
    property p_irq_quiet;
        since_wr >= 4'h6 |-> $stable(irq);
    endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt moved when idle");
endmodule
`default_nettype wire

// >>> emcc_host.sv
`timescale 1ns/10ps
`default_nettype none
module emcc_host
(
    // Clock
    input wire logic hclk,
    // Request
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [31:0] hwdata,
    // Answer
    input wire logic hready,
    input wire logic [31:0] hrdata
);
    initial
    begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
    end
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        q = hrdata;
        // Stale data never lingers on the wires
        hwdata <= ~d;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask
    task automatic send_cdb(input logic [7:0] opc, input logic [15:0] xp,
        input logic [15:0] src, input logic [15:0] d1, input logic [15:0] d2,
        input logic [1:0] flip);
        wr(8'h04, {opc, 8'h00, xp});
        wr(8'h08, {src, d1});
        wr(8'h0C, {d2, 6'h00, flip, 8'h00});
    endtask
endmodule
`default_nettype wire

// >>> emcc_tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    wire logic hsel;
    wire logic hwrite;
    wire logic [1:0] htrans;
    wire logic [2:0] hsize;
    wire logic [31:0] haddr;
    wire logic [31:0] hwdata;
    wire logic [31:0] hrdata;
    wire logic hreadyout;
    wire logic hresp;
    wire logic irq;
    int n_mismatch = 0;
    int checks = 0;
    logic [15:0] handler = 16'h0001;
    always #2 hclk = ~hclk;
    emcc_exchange_checker dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq));
    emcc_host host_u (.hclk(hclk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));
    task automatic results();
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        logic [31:0] d;
        host_u.xfer(1'b0, a, 32'h0, d);
        cmp(d & m, exp);
    endtask
    function automatic logic [39:0] mk(logic [3:0] k, logic [7:0] a, logic [7:0] q, logic v,
        logic [15:0] f);
        return {2'h0, f, v, v, k, a, q};
    endfunction
    // Result layout: plan, pointer, pointer valid, C/D, key, ASC, ASCQ
    function automatic logic [39:0] predict(logic [17:0] e, logic alt, logic tmp, logic opc_ok,
        logic flip, logic [15:0] xp, logic swap);
        logic [15:0] fb;
        fb = 16'h0;
        if (!opc_ok) return mk(4'h5, 8'h20, 8'h00, 1'b1, 16'h0000);
        if (flip) return mk(4'h5, 8'h24, 8'h00, 1'b1, 16'h000A);
        if (xp != 16'h0 && xp != handler) fb = 16'h0002;
        else if (!e[0]) fb = 16'h0004;
        else if (!e[1]) fb = 16'h0006;
        else if (!e[2]) fb = 16'h0008;
        if (fb != 16'h0)
            return alt ? mk(4'h5, 8'h24, 8'h80, 1'b1, fb)
                : mk(4'h5, 8'h21, 8'h01, 1'b1, fb);
        if (e[12])
            return alt ? mk(4'h2, 8'h04, 8'h86, 1'b0, 16'h0)
                : mk(4'h5, 8'h80, 8'h03, 1'b0, 16'h0);
        if (e[13])
            return alt ? mk(4'h2, 8'h04, 8'h86, 1'b0, 16'h0)
                : mk(4'h5, 8'h80, 8'h04, 1'b0, 16'h0);
        if (e[14])
            return mk(4'h5, alt ? 8'h3B : 8'h80, alt ? 8'h83 : 8'h05, 1'b0, 16'h0);
        if (e[15])
            return mk(4'h5, alt ? 8'h3B : 8'h80, alt ? 8'h84 : 8'h06, 1'b0, 16'h0);
        if (e[9] && (e[6] || e[7] || e[8]))
            return mk(4'h5, 8'h80, 8'h07, 1'b1, e[6] ? 16'h4 : (e[7] ? 16'h6 : 16'h8));
        if (e[10]) return mk(4'h5, 8'h3B, alt ? 8'h83 : 8'h90, 1'b1, 16'h0004);
        if (e[11]) return mk(4'h5, 8'h80, 8'h01, 1'b1, 16'h0002);
        if (!e[3]) return mk(4'h5, 8'h3B, 8'h0E, 1'b1, 16'h0004);
        if (!e[4]) return mk(4'h5, 8'h80, 8'h00, 1'b1, 16'h0006);
        if (!swap && e[5]) return mk(4'h5, 8'h3B, 8'h0D, 1'b1, 16'h0008);
        if (e[17]) return mk(4'h2, 8'h04, 8'h00, 1'b0, 16'h0);
        if (!swap) return {2'h3, 38'h0};
        if (e[16]) return {2'h1, 38'h0};
        if (tmp) return {2'h2, 38'h0};
        return mk(4'h2, 8'h04, 8'h00, 1'b0, 16'h0);
    endfunction
    task automatic run_one(logic [17:0] e, logic [1:0] ctl, logic [7:0] opc, logic [1:0] flip,
        logic [15:0] xp, logic swap, logic [1:0] msk);
        logic [15:0] src;
        logic [39:0] x;
        logic [31:0] d;
        logic ok;
        int n;
        src = 16'($urandom);
        x = predict(e, ctl[1], ctl[0], opc == 8'hA6, |flip, xp, swap);
        ok = (x[19:16] == 4'h0);
        host_u.send_cdb(opc, xp, src, 16'($urandom), swap ? src : src ^ 16'h0100, flip);
        host_u.wr(8'h14, {14'h0, e});
        host_u.wr(8'h28, {30'h0, msk});
        host_u.wr(8'h24, 32'h3);
        host_u.wr(8'h00, {29'h0, ctl, 1'b1});
        n = 0;
        do
        begin
            host_u.xfer(1'b0, 8'h18, 32'h0, d);
            n++;
        end
        while (d[1:0] !== 2'b10 && n < 20);
        cmp({d[31:16] & {16{ok}}, d[5:4], d[2:0]},
            {ok ? (xp == 16'h0 ? handler : xp) : 16'h0, x[39:38], ok, 2'b10});
        rdc(8'h1C, 32'h003F_FFFF, {10'h0, x[21:0]});
        if (x[21])
            rdc(8'h20, 32'h0000_FFFF, {16'h0, x[37:22]});
        rdc(8'h00, 32'h7, {29'h0, ctl, 1'b0});
        rdc(8'h24, 32'h3, {30'h0, !ok, ok});
        cmp({31'h0, irq}, {31'h0, |(msk & {!ok, ok})});
        host_u.wr(8'h24, 32'h3);
        rdc(8'h24, 32'h3, 32'h0);
        cmp({31'h0, irq}, 32'h0);
    endtask
    initial
    begin
        #120000;
        n_mismatch++;
        results();
    end
    initial
    begin
        void'($urandom(32'h31f2));
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int a = 0; a <= 'h2C; a += 4)
            rdc(8'(a), 32'hFFFF_FFFF, a == 'h10 ? 32'h1 : 32'h0);
        host_u.wr(8'h2C, 32'hFFFF_FFFF);
        rdc(8'h2C, 32'hFFFF_FFFF, 32'h0);
        // Every fault bit alone, both sense tables, three-location moves only
        for (int b = 0; b < 36; b++)
            run_one(18'h1F ^ (18'h1 << (b % 18)), {b >= 18, 1'b0},
                8'hA6, 2'h0, 16'h0, 1'b0, 2'h3);
        // Free slot in the alternate sense table; private slot and no slot at all in the native table
        for (int i = 0; i < 4; i++)
            run_one(18'h1F | (18'(i[0]) << 16), {i[0], i[1]},
                8'hA6, 2'h0, handler, 1'b1, 2'h1);
        for (int i = 0; i < 200; i++)
        begin
            if ($urandom % 4 == 0)
            begin
                handler = 16'($urandom) | 16'h1;
                host_u.wr(8'h10, {16'h0, handler});
            end
            run_one(18'h1F ^ 18'($urandom & $urandom & $urandom), 2'($urandom),
                ($urandom % 16 == 0) ? 8'($urandom) : 8'hA6,
                ($urandom % 16 == 0) ? 2'($urandom) : 2'h0,
                ($urandom % 4 == 0) ? 16'($urandom) : (($urandom % 2) ? handler : 16'h0),
                1'($urandom), 2'($urandom));
        end
        results();
    end
endmodule
bind emcc_exchange_checker emcc_sva chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq));
`default_nettype wire
